// ---- logic/tpo_pkg.sv ----
/*
  Package for the timer waveform stage: register offsets, field layouts,
  reset values and mode encodings.
  Assumes a classic Wishbone slave with 32-bit data and byte addresses.
*/
package tpo_pkg;
  localparam int CNT_W = 16;

  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_SLAVE   = 8'h04;
  localparam logic [7:0] REG_CHAN    = 8'h08;
  localparam logic [7:0] REG_EVENT   = 8'h0c;
  localparam logic [7:0] REG_COUNTER = 8'h10;
  localparam logic [7:0] REG_RELOAD  = 8'h14;
  localparam logic [7:0] REG_COMPARE = 8'h18;
  localparam logic [7:0] REG_STATUS  = 8'h1c;

  // Control register fields
  localparam int CTRL_EN_BIT     = 0;
  localparam int CTRL_SP_BIT     = 3;
  localparam int CTRL_DIR_BIT    = 4;
  localparam int CTRL_CAS_LO     = 5;
  localparam int CTRL_RELOAD_PRELOAD_ENABLE_BIT   = 7;
  // Slave register fields
  localparam int SLV_SMS_LO      = 0;
  localparam int SLV_TS_LO       = 4;
  localparam int SLV_TRIGGER_PRESCALER_LO     = 12;
  localparam int SLV_ECE_BIT     = 14;
  // Channel register fields
  localparam int CH_IN2_LO       = 8;
  localparam int CH_FE_BIT       = 2;
  localparam int CH_PE_BIT       = 3;
  localparam int CH_OCM_LO       = 4;
  localparam int CH_CE_BIT       = 7;
  // Event register / status register fields
  localparam int EVT_UPD_BIT     = 0;
  localparam int ST_UIF_BIT      = 0;
  localparam int ST_CCF_BIT      = 1;
  localparam int ST_REF_BIT      = 8;

  localparam logic [1:0] CAS_EDGE     = 2'h0;
  localparam logic [1:0] CAS_DOWNFLAG = 2'h1;
  localparam logic [1:0] CAS_UPFLAG   = 2'h2;
  localparam logic [1:0] CAS_BOTH     = 2'h3;

  localparam logic [2:0] OCM_FROZEN   = 3'h0;
  localparam logic [2:0] OCM_SET      = 3'h1;
  localparam logic [2:0] OCM_CLR      = 3'h2;
  localparam logic [2:0] OCM_TOGGLE   = 3'h3;
  localparam logic [2:0] OCM_FORCE_LO = 3'h4;
  localparam logic [2:0] OCM_FORCE_HI = 3'h5;
  localparam logic [2:0] OCM_PWM1     = 3'h6;
  localparam logic [2:0] OCM_PWM2     = 3'h7;

  localparam logic [2:0] TS_CH2       = 3'h6;
  localparam logic [2:0] SMS_TRIGGER  = 3'h6;
  localparam logic [1:0] IN2_MAP_CH2  = 2'h1;

  localparam logic [CNT_W-1:0] RELOAD_RST = 16'hffff;
  localparam logic [CNT_W-1:0] CNT_ZERO   = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_ONE    = 16'h0001;
endpackage

// ---- logic/tpo_timer_pwm.sv ----
/*
  Timer waveform stage: counter, compare and reload shadows, PWM and single
  pulse generation, fast output enable and reference clearing.
  Assumes a Wishbone classic master on ref_clk_i and asynchronous trigger pins
  which are resynchronised here.
*/
// Our own choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
module tpo_timer_pwm (
  input  wire logic                     ref_clk_i,
  input  wire logic                     rst_i,
  input  wire logic                     wb_cyc_i,
  input  wire logic                     wb_stb_i,
  input  wire logic                     wb_we_i,
  input  wire logic [7:0]               wb_adr_i,
  input  wire logic [3:0]               wb_sel_i,
  input  wire logic [31:0]              wb_dat_i,
  output logic      [31:0]              wb_dat_o,
  output logic                          wb_ack_o,
  input  wire logic                     channel2_input_i,
  input  wire logic                     filtered_external_trigger_i,
  output logic                          reference_output_o,
  output logic [tpo_pkg::CNT_W-1:0]     counter_value_o
);
  import tpo_pkg::*;

  typedef enum logic [1:0] {TPO_IDLE, TPO_ACK} tpo_bus_e;

  tpo_bus_e            bus_state;
  logic                counter_enable;
  logic                single_pulse_select;
  logic                dir;
  logic [1:0]          center_align_select;
  logic                reload_preload_enable;
  logic [2:0]          slave_mode_select;
  logic [2:0]          trigger_source_select;
  logic [1:0]          trigger_prescaler;
  logic                ext_clock_mode2_enable;
  logic [1:0]          channel2_input_select;
  logic                fast_output_enable;
  logic                compare_preload_enable;
  logic [2:0]          output_compare_mode;
  logic                reference_clear_enable;
  logic [CNT_W-1:0]    counter_value;
  logic [CNT_W-1:0]    reload_pre;
  logic [CNT_W-1:0]    reload_value;
  logic [CNT_W-1:0]    compare_pre;
  logic [CNT_W-1:0]    compare_value;
  logic                update_flag;
  logic                compare_flag;
  logic                ref_q;
  logic                clear_latched;
  logic                fast_held;
  logic [1:0]          ch2_sync;
  logic [1:0]          etr_sync;
  logic                ch2_prev;

  logic                bus_req;
  logic                wr_req;
  logic                wr_ctrl;
  logic                wr_cnt;
  logic                force_update;
  logic                trig_edge;
  logic                trig_start;
  logic                at_top;
  logic                at_bottom;
  logic                update_event;
  logic                compare_hit;
  logic                pwm1_level;
  logic                pwm_mode;
  logic                forced_mode;
  logic                next_dir;
  logic                etr_high;

  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Bus slave: one wait state, ack exactly one cycle, writes take at ack
  assign bus_req = wb_cyc_i && wb_stb_i && (bus_state == TPO_IDLE);
  assign wr_req  = bus_req && wb_we_i;
  assign wr_ctrl = wr_req && (wb_adr_i == REG_CTRL);
  assign wr_cnt  = wr_req && (wb_adr_i == REG_COUNTER);
  assign force_update = wr_req && (wb_adr_i == REG_EVENT) && wb_sel_i[0]
                        && wb_dat_i[EVT_UPD_BIT];

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      bus_state <= TPO_IDLE;
      wb_ack_o  <= 1'b0;
    end else begin
      unique case (bus_state)
        TPO_IDLE: begin
          wb_ack_o <= bus_req;
          if (bus_req) begin
            bus_state <= TPO_ACK;
          end
        end
        TPO_ACK: begin
          wb_ack_o  <= 1'b0;
          bus_state <= TPO_IDLE;
        end
        default: begin
          wb_ack_o  <= 1'b0;
          bus_state <= TPO_IDLE;
        end
      endcase
    end
  end

  // Read data captured with the request; unmapped offsets read as zero
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      wb_dat_o <= 32'h0000_0000;
      unique case (wb_adr_i)
        REG_CTRL: begin
          wb_dat_o[CTRL_EN_BIT]              <= counter_enable;
          wb_dat_o[CTRL_SP_BIT]              <= single_pulse_select;
          wb_dat_o[CTRL_DIR_BIT]             <= dir;
          wb_dat_o[CTRL_CAS_LO +: 2]         <= center_align_select;
          wb_dat_o[CTRL_RELOAD_PRELOAD_ENABLE_BIT]            <= reload_preload_enable;
        end
        REG_SLAVE: begin
          wb_dat_o[SLV_SMS_LO +: 3]          <= slave_mode_select;
          wb_dat_o[SLV_TS_LO +: 3]           <= trigger_source_select;
          wb_dat_o[SLV_TRIGGER_PRESCALER_LO +: 2]         <= trigger_prescaler;
          wb_dat_o[SLV_ECE_BIT]              <= ext_clock_mode2_enable;
        end
        REG_CHAN: begin
          wb_dat_o[CH_IN2_LO +: 2]           <= channel2_input_select;
          wb_dat_o[CH_FE_BIT]                <= fast_output_enable;
          wb_dat_o[CH_PE_BIT]                <= compare_preload_enable;
          wb_dat_o[CH_OCM_LO +: 3]           <= output_compare_mode;
          wb_dat_o[CH_CE_BIT]                <= reference_clear_enable;
        end
        REG_COUNTER: wb_dat_o[CNT_W-1:0]     <= counter_value;
        REG_RELOAD:  wb_dat_o[CNT_W-1:0]     <= reload_pre;
        REG_COMPARE: wb_dat_o[CNT_W-1:0]     <= compare_pre;
        REG_STATUS: begin
          wb_dat_o[ST_UIF_BIT]               <= update_flag;
          wb_dat_o[ST_CCF_BIT]               <= compare_flag;
          wb_dat_o[ST_REF_BIT]               <= ref_q;
        end
        default: wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Configuration registers (the preloads live in the counter process)
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      single_pulse_select    <= 1'b0;
      center_align_select    <= CAS_EDGE;
      reload_preload_enable  <= 1'b0;
      slave_mode_select      <= 3'h0;
      trigger_source_select  <= 3'h0;
      trigger_prescaler      <= 2'h0;
      ext_clock_mode2_enable <= 1'b0;
      channel2_input_select  <= 2'h0;
      fast_output_enable     <= 1'b0;
      compare_preload_enable <= 1'b0;
      output_compare_mode    <= OCM_FROZEN;
      reference_clear_enable <= 1'b0;
    end else if (wr_req) begin
      if (wb_adr_i == REG_CTRL && wb_sel_i[0]) begin
        single_pulse_select   <= wb_dat_i[CTRL_SP_BIT];
        center_align_select   <= wb_dat_i[CTRL_CAS_LO +: 2];
        reload_preload_enable <= wb_dat_i[CTRL_RELOAD_PRELOAD_ENABLE_BIT];
      end
      if (wb_adr_i == REG_SLAVE) begin
        if (wb_sel_i[0]) begin
          slave_mode_select     <= wb_dat_i[SLV_SMS_LO +: 3];
          trigger_source_select <= wb_dat_i[SLV_TS_LO +: 3];
        end
        if (wb_sel_i[1]) begin
          trigger_prescaler      <= wb_dat_i[SLV_TRIGGER_PRESCALER_LO +: 2];
          ext_clock_mode2_enable <= wb_dat_i[SLV_ECE_BIT];
        end
      end
      if (wb_adr_i == REG_CHAN) begin
        if (wb_sel_i[0]) begin
          fast_output_enable     <= wb_dat_i[CH_FE_BIT];
          compare_preload_enable <= wb_dat_i[CH_PE_BIT];
          output_compare_mode    <= wb_dat_i[CH_OCM_LO +: 3];
          reference_clear_enable <= wb_dat_i[CH_CE_BIT];
        end
        if (wb_sel_i[1]) begin
          channel2_input_select <= wb_dat_i[CH_IN2_LO +: 2];
        end
      end
    end
  end

  // Pins pass two flip-flops; only the second stage is read
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ch2_sync <= 2'b00;
      etr_sync <= 2'b00;
      ch2_prev <= 1'b0;
    end else begin
      ch2_sync <= {ch2_sync[0], channel2_input_i};
      etr_sync <= {etr_sync[0], filtered_external_trigger_i};
      ch2_prev <= ch2_sync[1];
    end
  end

  // Rising edge on the mapped channel two input starts the counter
  assign trig_edge  = ch2_sync[1] && !ch2_prev;
  assign trig_start = trig_edge && (trigger_source_select == TS_CH2)
                      && (slave_mode_select == SMS_TRIGGER)
                      && (channel2_input_select == IN2_MAP_CH2);
  assign etr_high   = etr_sync[1];

  assign at_top    = (counter_value >= reload_value);
  assign at_bottom = (counter_value == CNT_ZERO);
  // Update at rollover: edge-aligned wraps at either end, center at bottom/top
  always_comb begin
    update_event = 1'b0;
    if (counter_enable) begin
      if (center_align_select == CAS_EDGE) begin
        update_event = dir ? at_bottom : at_top;
      end else begin
        update_event = dir ? (counter_value == CNT_ONE) : (counter_value == reload_value - CNT_ONE);
      end
    end
    update_event = update_event || force_update;
  end

  // Counter, direction, enable and shadow registers
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      counter_value  <= CNT_ZERO;
      counter_enable <= 1'b0;
      dir            <= 1'b0;
      reload_pre     <= RELOAD_RST;
      reload_value   <= RELOAD_RST;
      compare_pre    <= CNT_ZERO;
      compare_value  <= CNT_ZERO;
    end else begin
      dir <= next_dir;
      if (wr_ctrl && wb_sel_i[0]) begin
        counter_enable <= wb_dat_i[CTRL_EN_BIT];
      end
      if (trig_start) begin
        counter_enable <= 1'b1;
      end else if (update_event && !force_update && single_pulse_select) begin
        counter_enable <= 1'b0;
      end
      if (wr_req && wb_adr_i == REG_RELOAD) begin
        reload_pre <= merge_bytes({16'h0000, reload_pre}, wb_dat_i, wb_sel_i)
                      [CNT_W-1:0];
      end
      if (wr_req && wb_adr_i == REG_COMPARE) begin
        compare_pre <= merge_bytes({16'h0000, compare_pre}, wb_dat_i, wb_sel_i)
                       [CNT_W-1:0];
      end
      // Shadows follow preloads only at update when preload is on
      if (!reload_preload_enable || update_event) begin
        reload_value <= (wr_req && wb_adr_i == REG_RELOAD) ? wb_dat_i[CNT_W-1:0] : reload_pre;
      end
      if (!compare_preload_enable || update_event) begin
        compare_value <= (wr_req && wb_adr_i == REG_COMPARE) ? wb_dat_i[CNT_W-1:0]
                                                             : compare_pre;
      end
      if (wr_cnt) begin
        counter_value <= wb_dat_i[CNT_W-1:0];
      end else if (force_update) begin
        counter_value <= dir ? reload_value : CNT_ZERO;
      end else if (counter_enable) begin
        if (center_align_select == CAS_EDGE) begin
          if (!dir) begin
            counter_value <= at_top ? CNT_ZERO : counter_value + CNT_ONE;
          end else begin
            counter_value <= at_bottom ? reload_value : counter_value - CNT_ONE;
          end
        end else begin
          counter_value <= dir ? counter_value - CNT_ONE : counter_value + CNT_ONE;
        end
      end
    end
  end

  // Direction: software in edge mode, hardware in center mode
  always_comb begin
    next_dir = dir;
    if (center_align_select == CAS_EDGE) begin
      if (wr_ctrl && wb_sel_i[0]) begin
        next_dir = wb_dat_i[CTRL_DIR_BIT];
      end
    end else if (wr_cnt) begin
      // Loads of zero or the reload value turn around; above reload keeps it
      if (wb_dat_i[CNT_W-1:0] == CNT_ZERO) begin
        next_dir = 1'b0;
      end else if (wb_dat_i[CNT_W-1:0] == reload_value) begin
        next_dir = 1'b1;
      end
    end else if (counter_enable) begin
      if (!dir && counter_value == reload_value - CNT_ONE) begin
        next_dir = 1'b1;
      end else if (dir && counter_value == CNT_ONE) begin
        next_dir = 1'b0;
      end
    end
  end

  // PWM mode 1 level from the live comparison
  always_comb begin
    if (compare_value > reload_value) begin
      pwm1_level = 1'b1;
    end else if (!dir) begin
      pwm1_level = counter_value < compare_value;
    end else begin
      pwm1_level = !(counter_value > compare_value);
    end
  end

  assign pwm_mode    = (output_compare_mode == OCM_PWM1) || (output_compare_mode == OCM_PWM2);
  assign forced_mode = (output_compare_mode == OCM_FORCE_LO)
                       || (output_compare_mode == OCM_FORCE_HI);
  assign compare_hit = counter_enable && (counter_value == compare_value);

  // Clear latch holds until the next update event, set beats clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      clear_latched <= 1'b0;
    end else if (reference_clear_enable && etr_high && !forced_mode) begin
      clear_latched <= 1'b1;
    end else if (update_event) begin
      clear_latched <= 1'b0;
    end
  end

  // Fast start keeps the match level until the period ends, so the reference
  // does not drop back while the counter still sits below the compare value
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fast_held <= 1'b0;
    end else if (fast_output_enable && pwm_mode && trig_start) begin
      fast_held <= 1'b1;
    end else if (update_event) begin
      fast_held <= 1'b0;
    end
  end

  // Reference output stage
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_q <= 1'b0;
    end else begin
      unique case (output_compare_mode)
        OCM_FROZEN:   ref_q <= ref_q;
        OCM_SET:      ref_q <= compare_hit ? 1'b1 : ref_q;
        OCM_CLR:      ref_q <= compare_hit ? 1'b0 : ref_q;
        OCM_TOGGLE:   ref_q <= compare_hit ? !ref_q : ref_q;
        OCM_FORCE_LO: ref_q <= 1'b0;
        OCM_FORCE_HI: ref_q <= 1'b1;
        OCM_PWM1:     ref_q <= pwm1_level;
        OCM_PWM2:     ref_q <= !pwm1_level;
      endcase
      // Fast enable: jump to the compare-match level on the trigger itself
      if ((fast_output_enable && pwm_mode && trig_start) || (fast_held && pwm_mode)) begin
        ref_q <= (output_compare_mode == OCM_PWM2);
      end
      if (!forced_mode && (clear_latched
          || (reference_clear_enable && etr_high))) begin
        ref_q <= 1'b0;
      end
    end
  end

  // Compare flag, direction gated in center modes 1 and 2; set wins over clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      compare_flag <= 1'b0;
      update_flag  <= 1'b0;
    end else begin
      if (compare_hit && (center_align_select == CAS_EDGE
          || center_align_select == CAS_BOTH
          || (center_align_select == CAS_DOWNFLAG && dir)
          || (center_align_select == CAS_UPFLAG && !dir))) begin
        compare_flag <= 1'b1;
      end else if (wr_req && wb_adr_i == REG_STATUS && wb_sel_i[0]
                   && !wb_dat_i[ST_CCF_BIT]) begin
        compare_flag <= 1'b0;
      end
      if (update_event) begin
        update_flag <= 1'b1;
      end else if (wr_req && wb_adr_i == REG_STATUS && wb_sel_i[0]
                   && !wb_dat_i[ST_UIF_BIT]) begin
        update_flag <= 1'b0;
      end
    end
  end

  assign reference_output_o = ref_q;
  assign counter_value_o    = counter_value;
endmodule

// ---- dv/tpo_pin_model.sv ----
/*
  Pin model for the trigger pin and the reference load: stretches a trigger
  request into a pin pulse and counts how long the reference stays high.
  Assumes commands arrive from the bench on the rising edge of clk_i.
*/
`timescale 1ns/1ps
module tpo_pin_model (
  input  wire logic        clk_i,
  input  wire logic        fire_i,
  input  wire logic        clear_i,
  input  wire logic        ref_i,
  output logic             trig_o,
  output logic             etr_o,
  output logic [15:0]      high_len_o
);
  logic [2:0] hold;

  initial begin
    hold = 3'h0;
    trig_o = 1'b0;
    etr_o = 1'b0;
    high_len_o = 16'h0;
  end

  // Held for several cycles so the edge survives the two-stage resync
  always @(posedge clk_i) begin
    hold <= fire_i ? 3'h4 : hold - {2'h0, hold != 3'h0};
    trig_o <= fire_i || hold > 3'h1;
    etr_o <= clear_i;
    high_len_o <= fire_i ? 16'h0 : high_len_o + {15'h0, ref_i};
  end
endmodule

// ---- dv/tpo_timer_pwm_chk.sv ----
/*
  Port-level checker for the timer waveform stage, bound to its top module.
  Assumes a classic single-cycle bus master and a shadow of the channel mode.
*/
`timescale 1ns/1ps
module tpo_chk
  import tpo_pkg::*;
(
  input wire logic              ref_clk_i,
  input wire logic              rst_i,
  input wire logic              wb_cyc_i,
  input wire logic              wb_stb_i,
  input wire logic              wb_we_i,
  input wire logic [7:0]        wb_adr_i,
  input wire logic [3:0]        wb_sel_i,
  input wire logic [31:0]       wb_dat_i,
  input wire logic [31:0]       wb_dat_o,
  input wire logic              wb_ack_o,
  input wire logic              channel2_input_i,
  input wire logic              filtered_external_trigger_i,
  input wire logic              reference_output_o,
  input wire logic [CNT_W-1:0]  counter_value_o
);
  logic [2:0] ocm;
  logic       ce;
  logic       forced;

  assign forced = ocm == OCM_FORCE_LO || ocm == OCM_FORCE_HI;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ocm <= 3'h0;
      ce <= 1'b0;
    end else if (wb_ack_o && wb_we_i && wb_adr_i == REG_CHAN && wb_sel_i[0]) begin
      ocm <= wb_dat_i[CH_OCM_LO +: 3];
      ce <= wb_dat_i[CH_CE_BIT];
    end
  end

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  property p_ack_idle; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i > REG_STATUS |-> wb_dat_o == 32'h0;
  endproperty
  property p_status_ref; wb_ack_o && !wb_we_i && wb_adr_i == REG_STATUS
    |-> wb_dat_o[ST_REF_BIT] == $past(reference_output_o); endproperty
  property p_cnt_step; $changed(counter_value_o) && !(wb_ack_o && wb_we_i)
    |-> counter_value_o == $past(counter_value_o) + 16'h1 || $past(counter_value_o) == 16'h0
        || counter_value_o == $past(counter_value_o) - 16'h1 || counter_value_o == 16'h0;
  endproperty
  property p_clear; ce && !forced && filtered_external_trigger_i [*5] |-> !reference_output_o;
  endproperty
  property p_forced; forced && $past(forced) && $stable(ocm) |-> reference_output_o == ocm[0];
  endproperty

  a_ack_pulse: assert property (p_ack_pulse)
    else $error("ack held past one cycle");
  a_ack_next: assert property (p_ack_next)
    else $error("request not answered next cycle");
  a_ack_idle: assert property (p_ack_idle)
    else $error("ack without request");
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  a_status_ref: assert property (p_status_ref)
    else $error("status reference bit differs from output");
  a_cnt_step: assert property (p_cnt_step)
    else $error("counter jumped");
  a_clear: assert property (p_clear)
    else $error("reference not cleared by trigger");
  a_forced: assert property (p_forced)
    else $error("forced level lost");

  c_clear: cover property (ce && filtered_external_trigger_i ##5 !reference_output_o);
  c_rise: cover property ($rose(reference_output_o));
  c_unmapped: cover property (wb_ack_o && wb_adr_i > REG_STATUS);
endmodule

bind tpo_timer_pwm tpo_chk tpo_chk_inst (.*);

// ---- dv/timer_pwm_one_pulse_output_test.sv ----
/*
  Self-checking bench for the timer waveform stage with its pin model.
  Assumes a one-cycle bus answer and a counter ticking on every clock.
*/
`timescale 1ns/1ps
module timer_pwm_one_pulse_output_test;
  import tpo_pkg::*;
  logic        clk, rst, cyc, stb, we, ack, trig, etr, pref, fire, clr;
  logic [7:0]  adr;
  logic [31:0] dw, dr, q, e;
  logic [15:0] cnt, hlen;
  int          miscompares, n_compared;
  logic [31:0] cmps [3] = '{32'h0, 32'h4, 32'ha};

  tpo_timer_pwm tpo_timer_pwm_inst (.ref_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dw),
    .wb_dat_o(dr), .wb_ack_o(ack), .channel2_input_i(trig),
    .filtered_external_trigger_i(etr), .reference_output_o(pref), .counter_value_o(cnt));
  tpo_pin_model tpo_pin_model_inst (.clk_i(clk), .fire_i(fire), .clear_i(clr), .ref_i(pref),
    .trig_o(trig), .etr_o(etr), .high_len_o(hlen));

  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Ack and read data are taken before this edge's updates land
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dw <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = dr;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) begin
      miscompares++;
      print_verdict();
    end
  endtask

  // Stop first, then leave center mode with the direction as read, so that
  // direction and center select never change in one write
  task automatic cfg(input logic [31:0] chan, input logic [31:0] cmp, input logic [31:0] ctrl);
    wb(1'b0, REG_CTRL, 32'h0);
    wb(1'b1, REG_CTRL, q & ~32'h1);
    wb(1'b0, REG_CTRL, 32'h0);
    wb(1'b1, REG_CTRL, q & ~(32'h3 << CTRL_CAS_LO));
    wb(1'b1, REG_CTRL, ctrl & ~(32'h1 | (32'h3 << CTRL_CAS_LO)));
    wb(1'b1, REG_CHAN, chan);
    wb(1'b1, REG_COMPARE, cmp);
    wb(1'b1, REG_EVENT, 32'h1);
    wb(1'b1, REG_CTRL, ctrl);
  endtask

  task automatic wait_cnt(input logic [15:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cnt !== v && n < 200);
    if (n >= 200) begin
      miscompares++;
      print_verdict();
    end
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    {rst, cyc, stb, we, fire, clr, adr, dw} = {6'h20, 8'h0, 32'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wb(1'b0, REG_RELOAD, 32'h0);
    check("reload reset", q, 32'h0000ffff);
    wb(1'b1, 8'h20, 32'h5a);
    wb(1'b0, 8'h20, 32'h0);
    check("unmapped read", q, 32'h0);
    wb(1'b1, REG_RELOAD, 32'h9);
    for (int d = 0; d < 2; d++) begin
      for (int m = 0; m < 2; m++) begin
        foreach (cmps[i]) begin
          e = (cmps[i] > 32'h9) ? 32'ha : cmps[i] + 32'(d);
          if (m == 1)
            e = 32'ha - e;
          cfg((32'(OCM_PWM1 + m) << CH_OCM_LO) | (32'h1 << CH_PE_BIT), cmps[i],
              (32'(d) << CTRL_DIR_BIT) | 32'h1);
          repeat (12) @(posedge clk);
          q = 0;
          repeat (10) @(posedge clk) q = q + 32'(pref);
          check("duty", q, e);
        end
      end
    end
    wb(1'b1, REG_SLAVE, (32'(TS_CH2) << SLV_TS_LO) | 32'(SMS_TRIGGER));
    for (int f = 0; f < 2; f++) begin
      cfg((32'(IN2_MAP_CH2) << CH_IN2_LO) | (32'(OCM_PWM2) << CH_OCM_LO)
          | (32'(f) << CH_FE_BIT), 32'h3, 32'h1 << CTRL_SP_BIT);
      fire <= 1'b1;
      @(posedge clk);
      fire <= 1'b0;
      repeat (30) @(posedge clk);
      // Fast start is high from the enabling cycle through all ten counts
      check("pulse length", 32'(hlen), f ? 32'hb : 32'h7);
      check("stopped count", 32'(cnt), 32'h0);
      wb(1'b0, REG_CTRL, 32'h0);
      check("enable cleared", q, 32'h1 << CTRL_SP_BIT);
    end
    wb(1'b1, REG_SLAVE, 32'h0);
    cfg(32'(OCM_PWM1) << CH_OCM_LO, 32'h4, (32'h1 << CTRL_DIR_BIT) | (32'h1 << CTRL_CAS_LO) | 32'h1);
    wait_cnt(16'h5);
    @(posedge clk);
    check("center start", 32'(cnt), 32'h4);
    cfg((32'(OCM_PWM1) << CH_OCM_LO) | (32'h1 << CH_CE_BIT), 32'ha, 32'h1);
    wait_cnt(16'h1);
    // Trigger must be low again by the wrap, else the clear holds a period more
    clr <= 1'b1;
    repeat (4) @(posedge clk);
    clr <= 1'b0;
    repeat (2) @(posedge clk);
    check("cleared", 32'(pref), 32'h0);
    wait_cnt(16'h2);
    check("restored", 32'(pref), 32'h1);
    wb(1'b1, REG_CHAN, (32'(OCM_FORCE_HI) << CH_OCM_LO) | (32'h1 << CH_CE_BIT));
    clr <= 1'b1;
    repeat (6) @(posedge clk);
    check("forced high", 32'(pref), 32'h1);
    wb(1'b0, REG_STATUS, 32'h0);
    check("status reference", 32'(q[ST_REF_BIT]), 32'h1);
    print_verdict();
  end
endmodule
